// File: bench/cpi_bus_node.sv
// Model of the CAN bus as seen through the transceiver: bit timing and receive level
`timescale 1ns/100ps

module cpi_bus_node #(
  parameter int BIT_CYC = 4
) (
  // Clock
  input wire logic clk,
  // Command
  input wire logic dominant,
  // Bus view
  output logic     bitTick,
  output logic     rxPin
);
  logic [7:0] cnt;

  // Idle bus floats recessive through the termination
  initial begin
    cnt = 8'h00;
    bitTick = 1'b0;
    rxPin = 1'b1;
  end

  // Level changes only at bit boundaries, as on a real bus
  always @(posedge clk) begin
    cnt <= (cnt == 8'(BIT_CYC - 1)) ? 8'h00 : cnt + 8'h01;
    bitTick <= (cnt == 8'(BIT_CYC - 1));
    if (cnt == 8'(BIT_CYC - 1)) rxPin <= !dominant;
  end
endmodule

// File: bench/cpi_can_ctrl_sva.sv
// Checker of the CAN power and interrupt block, bound to its ports
`timescale 1ns/100ps
`include "cpi_consts.svh"

module cpi_can_ctrl_chk #(
  parameter int ADDR_W  = 12,
  parameter int TX_BUFS = 3
) (
  // Clock and reset
  input wire logic               clk,
  input wire logic               nrst,
  // Bus side
  input wire logic               hsel,
  input wire logic [ADDR_W-1:0]  haddr,
  input wire logic [1:0]         htrans,
  input wire logic               hwrite,
  input wire logic               hready,
  input wire logic [31:0]        hrdata,
  input wire logic               hreadyout,
  input wire logic               hresp,
  // Engine side
  input wire logic               cpuStop,
  input wire logic               bitTick,
  input wire logic               rxPin,
  input wire logic [TX_BUFS-1:0] txSent,
  input wire logic [8:0]         rxErrCount,
  input wire logic [8:0]         txErrCount,
  input wire logic               engineRun,
  input wire logic [TX_BUFS-1:0] txScheduled,
  input wire logic               bus_tx_pin,
  input wire logic               txIrq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // ---------------------------------------------
  // Consecutive recessive bits seen on the bus
  // ---------------------------------------------
  logic [3:0] recCnt;

  // Saturates so a long idle bus never wraps back below eleven
  always_ff @(posedge clk) begin
    if (!nrst) recCnt <= 4'h0;
    else if (bitTick) recCnt <= !rxPin ? 4'h0 : (recCnt == 4'hF ? recCnt : recCnt + 4'h1);
  end

  // ---------------------------------------------
  // Sequences and assertions
  // ---------------------------------------------
  sequence rdAt(logic [ADDR_W-1:0] a);
    hsel && hready && htrans[1] && !hwrite && !cpuStop && haddr == a;
  endsequence

  a_ready_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_tx_recessive: assert property (cpuStop [*3] |-> bus_tx_pin && !engineRun)
    else $error("pin driven or engine running while stopped");
  a_txirq_quiet: assert property ($past(&txScheduled) && &txScheduled |-> !txIrq)
    else $error("transmit interrupt with no empty buffer");
  a_sent_empty: assert property (|txSent |=> (txScheduled & $past(txSent)) == '0)
    else $error("sent buffer still scheduled");
  a_idle_wait: assert property ($rose(engineRun) |-> recCnt >= 4'd11)
    else $error("engine joined bus before eleven recessive bits");
  a_errcnt_read: assert property (rdAt(`CPI_OFS_ERRCNT) |=>
    hrdata[8:0] == $past(rxErrCount) && hrdata[23:16] == $past(txErrCount[7:0]))
    else $error("error counter read mismatch");
  a_unmapped_zero: assert property (rdAt(12'h040) |=> hrdata == 32'h00000000)
    else $error("unmapped read not zero");
  a_warn_flag: assert property (rdAt(`CPI_OFS_RXFLAG) ##0 ($past(nrst) &&
    $past(rxErrCount) >= 9'd96) |=> hrdata[6])
    else $error("receive warning flag missing");
  a_passive_flag: assert property (rdAt(`CPI_OFS_RXFLAG) ##0 ($past(nrst) &&
    $past(txErrCount) > 9'd127) |=> hrdata[3])
    else $error("transmit passive flag missing");
  a_busoff_flag: assert property (rdAt(`CPI_OFS_RXFLAG) ##0 ($past(nrst) &&
    $past(txErrCount) > 9'd255) |=> hrdata[2])
    else $error("bus-off flag missing");
endmodule

bind cpi_can_ctrl cpi_can_ctrl_chk #(.ADDR_W(ADDR_W), .TX_BUFS(TX_BUFS)) u_chk (
  .clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cpuStop(cpuStop),
  .bitTick(bitTick), .rxPin(rxPin), .txSent(txSent), .rxErrCount(rxErrCount),
  .txErrCount(txErrCount), .engineRun(engineRun), .txScheduled(txScheduled),
  .bus_tx_pin(bus_tx_pin), .txIrq(txIrq));

// File: bench/tb_can_controller_power_interrupts.sv
// Self-checking testbench of the CAN power and interrupt block
`timescale 1ns/100ps
`include "cpi_consts.svh"

module tb_can_controller_power_interrupts;
  // ---------------------------------------------
  // Signals
  // ---------------------------------------------
  logic        clk = 1'b0;
  logic        nrst, hsel, hwrite, hreadyout, hresp, cpuStop, bitTick, rxPin, dominant;
  logic        engineTxBusy, engineRxBusy, engineTx, frameDone, bgBufferValid, engineRun, copyAllowed, busTx;
  logic        abortAllowed, wakeIrq, errorIrq, rxIrq, txIrq;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic [31:0] hwdata, hrdata;
  logic [2:0]  txSent, txAborted, txScheduled;
  logic [8:0]  rxErrCount, txErrCount;
  int          errors, comparisons;

  always #10 clk = ~clk;

  cpi_can_ctrl DUT (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .cpuStop(cpuStop), .bitTick(bitTick), .rxPin(rxPin),
    .engineTx(engineTx), .engineRxBusy(engineRxBusy), .engineTxBusy(engineTxBusy), .frameDone(frameDone),
    .bgBufferValid(bgBufferValid), .txSent(txSent), .txAborted(txAborted), .rxErrCount(rxErrCount),
    .txErrCount(txErrCount), .engineRun(engineRun), .copyAllowed(copyAllowed), .abortAllowed(abortAllowed),
    .txScheduled(txScheduled), .bus_tx_pin(busTx), .wakeIrq(wakeIrq), .errorIrq(errorIrq),
    .rxIrq(rxIrq), .txIrq(txIrq));

  cpi_bus_node #(.BIT_CYC(4)) node (.clk(clk), .dominant(dominant), .bitTick(bitTick), .rxPin(rxPin));

  // ---------------------------------------------
  // Shared tasks
  // ---------------------------------------------
  task automatic finish_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Waits for ready at a rising edge; a hang ends the run
  task automatic waitRdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      $display("[FAIL] %0t bus timeout", $time);
      finish_test();
    end
  endtask

  // One AHB-Lite single word transfer, entered just after a rising edge
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    waitRdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    waitRdy();
    r = hrdata;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m = 32'hFFFFFFFF);
    logic [31:0] r;
    bus(1'b0, a, 32'h00000000, r);
    chk(r & m, exp);
  endtask

  task automatic pulseSent(input logic [2:0] b);
    txSent <= b;
    @(posedge clk);
    txSent <= 3'h0;
  endtask

  task automatic waitRun();
    int n;
    for (n = 0; n < 400 && engineRun !== 1'b1; n++) @(posedge clk);
    chk(32'(engineRun), 32'h1);
    if (engineRun !== 1'b1) finish_test();
  endtask

  // ---------------------------------------------
  // Scenarios
  // ---------------------------------------------
  task automatic t_lock();
    rd(`CPI_OFS_CTRL, 32'h2);
    rd(`CPI_OFS_STAT, 32'h4, 32'h7);
    rd(`CPI_OFS_TXFLAG, 32'h7);
    rd(12'h040, 32'h0);
    wr(`CPI_OFS_MASK, 32'h0000F100);
    rd(`CPI_OFS_MASK, 32'h0000F100);
    wr(`CPI_OFS_CTRL, 32'h0);
    wr(`CPI_OFS_MASK, 32'hFFFFFFFF);
    rd(`CPI_OFS_MASK, 32'h0000F100);
    wr(`CPI_OFS_ERRCNT, 32'hFFFFFFFF);
    rd(`CPI_OFS_ERRCNT, 32'h00070005);
    waitRun();
    chk(32'(busTx), 32'h0);
    $display("lock test done");
  endtask

  task automatic t_tx();
    wr(`CPI_OFS_TXEN, 32'h7);
    cyc(2);
    chk(32'(txIrq), 32'h1);
    wr(`CPI_OFS_TXFLAG, 32'h7);
    cyc(2);
    chk(32'(txIrq), 32'h0);
    pulseSent(3'h2);
    cyc(2);
    rd(`CPI_OFS_TXFLAG, 32'h2);
    chk(32'(txIrq), 32'h1);
    txAborted <= 3'h5;
    @(posedge clk);
    txAborted <= 3'h0;
    rd(`CPI_OFS_TXFLAG, 32'h7);
    wr(`CPI_OFS_TXEN, 32'h0);
    $display("transmit test done");
  endtask

  task automatic t_rx();
    wr(`CPI_OFS_RXEN, 32'h3);
    bgBufferValid <= 1'b1;
    frameDone <= 1'b1;
    @(posedge clk);
    frameDone <= 1'b0;
    cyc(3);
    chk(32'(rxIrq), 32'h1);
    frameDone <= 1'b1;
    @(posedge clk);
    frameDone <= 1'b0;
    cyc(3);
    rd(`CPI_OFS_RXFLAG, 32'h3, 32'h3);
    chk(32'(errorIrq), 32'h1);
    bgBufferValid <= 1'b0;
    wr(`CPI_OFS_RXFLAG, 32'h3);
    cyc(2);
    rd(`CPI_OFS_RXFLAG, 32'h0, 32'h3);
    chk(32'(rxIrq), 32'h0);
    wr(`CPI_OFS_RXEN, 32'h0);
    $display("receive test done");
  endtask

  task automatic t_sleep();
    wr(`CPI_OFS_TXFLAG, 32'h1);
    engineTxBusy <= 1'b1;
    engineRxBusy <= 1'b1;
    wr(`CPI_OFS_CTRL, 32'h1);
    cyc(4);
    rd(`CPI_OFS_STAT, 32'h0, 32'h1);
    engineTxBusy <= 1'b0;
    pulseSent(3'h1);
    cyc(4);
    rd(`CPI_OFS_STAT, 32'h0, 32'h1);
    engineRxBusy <= 1'b0;
    cyc(4);
    rd(`CPI_OFS_STAT, 32'h3, 32'h7);
    chk(32'({busTx, engineRun, copyAllowed, abortAllowed}), 32'h8);
    wr(`CPI_OFS_TXFLAG, 32'h1);
    rd(`CPI_OFS_TXFLAG, 32'h0, 32'h1);
    wr(`CPI_OFS_RXEN, 32'h80);
    dominant <= 1'b1;
    cyc(12);
    dominant <= 1'b0;
    chk(32'(wakeIrq), 32'h1);
    rd(`CPI_OFS_RXFLAG, 32'h80, 32'h80);
    rd(`CPI_OFS_STAT, 32'h0, 32'h7);
    wr(`CPI_OFS_RXFLAG, 32'h80);
    wr(`CPI_OFS_RXEN, 32'h0);
    chk(32'(wakeIrq), 32'h0);
    waitRun();
    $display("sleep test done");
  endtask

  task automatic t_errors();
    logic [8:0] rx[5] = '{9'd96, 9'd0, 9'd128, 9'd0, 9'd256};
    logic [8:0] tx[5] = '{9'd0, 9'd96, 9'd0, 9'd128, 9'd256};
    logic [7:0] ex[5] = '{8'h40, 8'h20, 8'h50, 8'h28, 8'h7C};
    wr(`CPI_OFS_RXEN, 32'h40);
    for (int i = 0; i < 5; i++) begin
      rxErrCount <= rx[i];
      txErrCount <= tx[i];
      cyc(3);
      rd(`CPI_OFS_RXFLAG, 32'(ex[i]), 32'h7C);
      chk(32'(errorIrq), 32'(ex[i][6]));
      wr(`CPI_OFS_RXFLAG, 32'(ex[i]));
      rd(`CPI_OFS_RXFLAG, 32'(ex[i]), 32'h7C);
      rxErrCount <= 9'd0;
      txErrCount <= 9'd0;
      cyc(2);
      wr(`CPI_OFS_RXFLAG, 32'(ex[i]));
      rd(`CPI_OFS_RXFLAG, 32'h0, 32'h7C);
    end
    wr(`CPI_OFS_RXEN, 32'h0);
    $display("error test done");
  endtask

  task automatic t_power();
    cpuStop <= 1'b1;
    cyc(3);
    chk(32'({busTx, engineRun}), 32'h2);
    wr(`CPI_OFS_CTRL, 32'h2);
    cpuStop <= 1'b0;
    cyc(2);
    rd(`CPI_OFS_CTRL, 32'h0, 32'h3);
    pulseSent(3'h1);
    wr(`CPI_OFS_CTRL, 32'h1);
    cyc(2);
    rd(`CPI_OFS_STAT, 32'h3, 32'h7);
    wr(`CPI_OFS_CTRL, 32'h3);
    cyc(2);
    chk(32'({busTx, engineRun}), 32'h2);
    rd(`CPI_OFS_STAT, 32'h4, 32'h7);
    $display("power test done");
  endtask

  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  initial begin
    {nrst, hsel, hwrite, cpuStop, dominant, engineTxBusy, engineRxBusy, engineTx, frameDone, bgBufferValid} = '0;
    {haddr, htrans, hwdata, txSent, txAborted} = '0;
    rxErrCount = 9'd5;
    txErrCount = 9'd7;
    errors = 0;
    comparisons = 0;
    cyc(8);
    nrst <= 1'b1;
    t_lock();
    t_tx();
    t_rx();
    t_sleep();
    t_errors();
    t_power();
    finish_test();
  end
endmodule

// File: logic/cpi_can_ctrl.sv
// CAN controller interrupt, protection and low-power control with an AHB-Lite register slave
`timescale 1ns/100ps
`include "cpi_consts.svh"

module cpi_can_ctrl #(
  parameter int ADDR_W = 12,
  parameter int TX_BUFS = 3
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                nrst,
  // AHB-Lite slave
  input  wire logic                hsel,
  input  wire logic [ADDR_W-1:0]   haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  // Protocol engine status
  input  wire logic                cpuStop,
  input  wire logic                bitTick,
  input  wire logic                rxPin,
  input  wire logic                engineTx,
  input  wire logic                engineRxBusy,
  input  wire logic                engineTxBusy,
  input  wire logic                frameDone,
  input  wire logic                bgBufferValid,
  input  wire logic [TX_BUFS-1:0]  txSent,
  input  wire logic [TX_BUFS-1:0]  txAborted,
  input  wire logic [8:0]          rxErrCount,
  input  wire logic [8:0]          txErrCount,
  // Engine control
  output logic                     engineRun,
  output logic                     copyAllowed,
  output logic                     abortAllowed,
  output logic [TX_BUFS-1:0]       txScheduled,
  output logic                     bus_tx_pin,
  // Interrupt lines
  output logic                     wakeIrq,
  output logic                     errorIrq,
  output logic                     rxIrq,
  output logic                     txIrq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  cpi_pkg::cpi_mode_t mode;
  logic       sleep_request;
  logic       soft_reset_lock;
  logic       sleep_acknowledge;
  logic [7:0] rx_flag_register;
  logic [7:0] rxEnable;
  logic [TX_BUFS-1:0] tx_empty_flag;
  logic [TX_BUFS-1:0] txEnable;
  logic [7:0] module_control_two;
  logic [7:0] bit_timing_reg_a;
  logic [7:0] bit_timing_reg_b;
  logic [7:0] filter_control_reg;
  logic [31:0] filter_accept_regs;
  logic [31:0] filter_mask_regs;
  logic       fgFull;
  logic       waking;
  logic       rxSeen;
  logic       synced;

  // Data-phase bookkeeping
  logic              dpWrite;
  logic              dpRead;
  logic [ADDR_W-1:0] dpAddr;
  logic [31:0]       next_rdata;

  // ----------------------------------------------------------------
  // Condition decode
  // ----------------------------------------------------------------
  logic [7:0] rxCond;
  logic       wakeEvent;
  logic       busActive;

  function automatic logic atLeast(input logic [8:0] cnt, input logic [8:0] lim);
    atLeast = cnt >= lim;
  endfunction

  // Sources raised by the engine, the error counters or the receive pin this cycle
  always_comb begin
    rxCond = `CPI_BYTE_RST;
    rxCond[`CPI_RX_FULL] = frameDone && bgBufferValid && !fgFull && mode == cpi_pkg::CPI_NORMAL;
    rxCond[`CPI_RX_OVR]  = frameDone && bgBufferValid && fgFull;
    rxCond[`CPI_RX_RWRN] = atLeast(rxErrCount, `CPI_WARN_LIMIT);
    rxCond[`CPI_RX_TWRN] = atLeast(txErrCount, `CPI_WARN_LIMIT);
    rxCond[`CPI_RX_RPAS] = rxErrCount > `CPI_PASS_LIMIT;
    rxCond[`CPI_RX_TPAS] = txErrCount > `CPI_PASS_LIMIT;
    rxCond[`CPI_RX_BOFF] = txErrCount > `CPI_BOFF_LIMIT;
    rxCond[`CPI_RX_WAKE] = wakeEvent;
  end

  // A dominant level on the receive pin while asleep or powered down
  assign busActive = !rxPin;
  assign wakeEvent = busActive && (mode == cpi_pkg::CPI_SLEEP || mode == cpi_pkg::CPI_POWERDOWN);

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  logic addrOk;

  // Power-down shuts the register file off entirely
  assign addrOk = hsel && hready && htrans[1] && mode != cpi_pkg::CPI_POWERDOWN;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      dpWrite <= 1'b0;
      dpRead  <= 1'b0;
      dpAddr  <= '0;
    end else if (hready) begin
      dpWrite <= addrOk && hwrite;
      dpRead  <= addrOk && !hwrite;
      dpAddr  <= haddr;
    end
  end

  // Zero wait states, always OKAY; constant, so reset needs no branch of its own
  always_ff @(posedge clk) begin
    hreadyout <= 1'b1;
    hresp     <= 1'b0;
  end

  logic wrCtrl;
  logic wrRxFlag;
  logic wrTxFlag;
  logic cfgWrite;

  assign wrCtrl   = dpWrite && dpAddr == `CPI_OFS_CTRL;
  assign wrRxFlag = dpWrite && dpAddr == `CPI_OFS_RXFLAG;
  assign wrTxFlag = dpWrite && dpAddr == `CPI_OFS_TXFLAG;
  assign cfgWrite = dpWrite && soft_reset_lock;

  // Read mux, registered in the address phase so hrdata is a flop
  always_comb begin
    next_rdata = `CPI_WORD_RST;
    unique case (haddr)
      `CPI_OFS_CTRL:     next_rdata[1:0] = {soft_reset_lock, sleep_request};
      `CPI_OFS_STAT:     next_rdata[3:0] = {synced, mode, sleep_acknowledge};
      `CPI_OFS_RXFLAG:   next_rdata[7:0] = rx_flag_register;
      `CPI_OFS_RXEN:     next_rdata[7:0] = rxEnable;
      `CPI_OFS_TXFLAG:   next_rdata[TX_BUFS-1:0] = tx_empty_flag;
      `CPI_OFS_TXEN:     next_rdata[TX_BUFS-1:0] = txEnable;
      `CPI_OFS_ERRCNT:   next_rdata[23:0] = {txErrCount[7:0], 7'h00, rxErrCount};
      `CPI_OFS_MODCTL2:  next_rdata[7:0] = module_control_two;
      `CPI_OFS_TIMING_A: next_rdata[7:0] = bit_timing_reg_a;
      `CPI_OFS_TIMING_B: next_rdata[7:0] = bit_timing_reg_b;
      `CPI_OFS_FCTRL:    next_rdata[7:0] = filter_control_reg;
      `CPI_OFS_ACCEPT:   next_rdata = filter_accept_regs;
      `CPI_OFS_MASK:     next_rdata = filter_mask_regs;
      default:           next_rdata = `CPI_WORD_RST;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      hrdata <= `CPI_WORD_RST;
    end else if (addrOk && !hwrite) begin
      hrdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Control and configuration registers
  // ----------------------------------------------------------------
  // Sleep request may only be dropped once acknowledged; the error counters have no write path at all
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sleep_request   <= 1'b0;
      soft_reset_lock <= 1'b1;
    end else if (wrCtrl) begin
      soft_reset_lock <= hwdata[`CPI_CTRL_SRES];
      if (hwdata[`CPI_CTRL_SLEEP_REQUEST] || sleep_acknowledge) begin
        sleep_request <= hwdata[`CPI_CTRL_SLEEP_REQUEST];
      end
    end else if (waking) begin
      sleep_request <= 1'b0;
    end
  end

  // Enables are free to change at any time
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rxEnable <= `CPI_BYTE_RST;
      txEnable <= '0;
    end else if (dpWrite && dpAddr == `CPI_OFS_RXEN) begin
      rxEnable <= hwdata[7:0];
    end else if (dpWrite && dpAddr == `CPI_OFS_TXEN) begin
      txEnable <= hwdata[TX_BUFS-1:0];
    end
  end

  // Locked configuration, writable only while held in soft reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      module_control_two <= `CPI_BYTE_RST;
      bit_timing_reg_a   <= `CPI_BYTE_RST;
      bit_timing_reg_b   <= `CPI_BYTE_RST;
      filter_control_reg <= `CPI_BYTE_RST;
      filter_accept_regs <= `CPI_WORD_RST;
      filter_mask_regs   <= `CPI_WORD_RST;
    end else if (cfgWrite) begin
      unique case (dpAddr)
        `CPI_OFS_MODCTL2:  module_control_two <= hwdata[7:0];
        `CPI_OFS_TIMING_A: bit_timing_reg_a   <= hwdata[7:0];
        `CPI_OFS_TIMING_B: bit_timing_reg_b   <= hwdata[7:0];
        `CPI_OFS_FCTRL:    filter_control_reg <= hwdata[7:0];
        `CPI_OFS_ACCEPT:   filter_accept_regs <= hwdata;
        `CPI_OFS_MASK:     filter_mask_regs   <= hwdata;
        default:           filter_mask_regs   <= filter_mask_regs;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------
  // Set beats clear; a still-present condition re-sets the flag
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rx_flag_register <= `CPI_BYTE_RST;
    end else begin
      rx_flag_register <= (rx_flag_register & ~(wrRxFlag ? hwdata[7:0] : `CPI_BYTE_RST)) | rxCond;
    end
  end

  // Foreground buffer occupancy tracks the receive-full flag
  assign fgFull = rx_flag_register[`CPI_RX_FULL];

  // Buffers not scheduled show empty; software clears to schedule
  logic [TX_BUFS-1:0] next_txEmpty;
  assign next_txEmpty = (tx_empty_flag & ~(wrTxFlag ? hwdata[TX_BUFS-1:0] : '0)) | txSent | txAborted;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      tx_empty_flag <= '1;
      txScheduled   <= '0;
    end else begin
      tx_empty_flag <= next_txEmpty;
      txScheduled   <= ~next_txEmpty; // Own flop, so the port needs no inverter
    end
  end

  // ----------------------------------------------------------------
  // Mode control
  // ----------------------------------------------------------------
  logic queueEmpty;
  cpi_pkg::cpi_mode_t next_mode;

  assign queueEmpty = &tx_empty_flag;

  // Stop wins; sleep waits until the engine has nothing left to finish
  always_comb begin
    next_mode = mode;
    waking    = 1'b0;
    if (cpuStop) begin
      next_mode = cpi_pkg::CPI_POWERDOWN;
    end else if (soft_reset_lock) begin
      next_mode = cpi_pkg::CPI_SOFTRESET;
      waking    = mode == cpi_pkg::CPI_SLEEP;
    end else if (mode == cpi_pkg::CPI_SLEEP) begin
      if (!sleep_request || busActive) begin
        next_mode = cpi_pkg::CPI_NORMAL;
        waking    = 1'b1;
      end
    end else if (sleep_request && !engineRxBusy && !(engineTxBusy || !queueEmpty)) begin
      next_mode = cpi_pkg::CPI_SLEEP;
    end else begin
      next_mode = cpi_pkg::CPI_NORMAL;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      mode              <= cpi_pkg::CPI_SOFTRESET;
      sleep_acknowledge <= 1'b0;
    end else begin
      mode              <= next_mode;
      sleep_acknowledge <= next_mode == cpi_pkg::CPI_SLEEP;
    end
  end

  // Restart the bus-idle wait whenever the engine is not running normally
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rxSeen <= 1'b0;
    end else begin
      rxSeen <= mode != cpi_pkg::CPI_NORMAL;
    end
  end

  cpi_idle_detect #(
    .BITS (`CPI_IDLE_BITS)
  ) u_idle (
    .clk     (clk),
    .nrst    (nrst),
    .restart (rxSeen),
    .bitTick (bitTick),
    .rxBit   (rxPin),
    .synced  (synced)
  );

  // Engine gating: protocol clocks stop outside normal mode; the transmit pin is held recessive with them
  always_ff @(posedge clk) begin
    if (!nrst) begin
      engineRun    <= 1'b0;
      copyAllowed  <= 1'b0;
      abortAllowed <= 1'b0;
      bus_tx_pin   <= 1'b1;
    end else begin
      engineRun    <= next_mode == cpi_pkg::CPI_NORMAL && synced;
      copyAllowed  <= next_mode == cpi_pkg::CPI_NORMAL;
      abortAllowed <= next_mode == cpi_pkg::CPI_NORMAL;
      bus_tx_pin   <= next_mode == cpi_pkg::CPI_NORMAL ? engineTx : 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt outputs
  // ----------------------------------------------------------------
  // Levels stay up while any enabled flag remains set; wake keeps the acknowledge seen at the event
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wakeIrq  <= 1'b0;
      errorIrq <= 1'b0;
      rxIrq    <= 1'b0;
      txIrq    <= 1'b0;
    end else begin
      wakeIrq  <= (rx_flag_register[`CPI_RX_WAKE] || wakeEvent) && rxEnable[`CPI_RX_WAKE]
                  && (sleep_acknowledge || wakeIrq);
      errorIrq <= |(rx_flag_register[6:1] & rxEnable[6:1]);
      rxIrq    <= rx_flag_register[`CPI_RX_FULL] && rxEnable[`CPI_RX_FULL];
      txIrq    <= |(tx_empty_flag & txEnable);
    end
  end

endmodule

// File: logic/cpi_consts.svh
// Register offsets, field positions, reset values and limits of the CAN power and interrupt block
`ifndef CPI_CONSTS_SVH
`define CPI_CONSTS_SVH

// Register byte offsets
`define CPI_OFS_CTRL     12'h000
`define CPI_OFS_STAT     12'h004
`define CPI_OFS_RXFLAG   12'h008
`define CPI_OFS_RXEN     12'h00C
`define CPI_OFS_TXFLAG   12'h010
`define CPI_OFS_TXEN     12'h014
`define CPI_OFS_ERRCNT   12'h018
`define CPI_OFS_MODCTL2  12'h01C
`define CPI_OFS_TIMING_A 12'h020
`define CPI_OFS_TIMING_B 12'h024
`define CPI_OFS_FCTRL    12'h028
`define CPI_OFS_ACCEPT   12'h02C
`define CPI_OFS_MASK     12'h030

// Control register fields
`define CPI_CTRL_SLEEP_REQUEST   0
`define CPI_CTRL_SRES    1
`define CPI_CTRL_RST     2'h2

// Receive flag register fields
`define CPI_RX_FULL      0
`define CPI_RX_OVR       1
`define CPI_RX_BOFF      2
`define CPI_RX_TPAS      3
`define CPI_RX_RPAS      4
`define CPI_RX_TWRN      5
`define CPI_RX_RWRN      6
`define CPI_RX_WAKE      7

// Error thresholds
`define CPI_WARN_LIMIT   9'd96
`define CPI_PASS_LIMIT   9'd127
`define CPI_BOFF_LIMIT   9'd255

// Recessive bits needed to join the bus
`define CPI_IDLE_BITS    4'd11

`define CPI_BYTE_RST     8'h00
`define CPI_WORD_RST     32'h00000000
`define CPI_ONE_WORD     32'h00000001

`endif

// File: logic/cpi_idle_detect.sv
// Counter of consecutive recessive bits that releases the controller onto the bus
`timescale 1ns/100ps
`include "cpi_consts.svh"

module cpi_idle_detect #(
  parameter int BITS = 11
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Bit stream
  input  wire logic restart,
  input  wire logic bitTick,
  input  wire logic rxBit,
  // Result
  output logic      synced
);

  logic [3:0] count;

  // A dominant bit before sync restarts the count, so a waking frame is dropped
  always_ff @(posedge clk) begin
    if (!nrst || restart) begin
      count  <= 4'h0;
      synced <= 1'b0;
    end else if (bitTick && !synced) begin
      if (!rxBit) begin
        count <= 4'h0;
      end else if (count == 4'(BITS - 1)) begin
        synced <= 1'b1;
      end else begin
        count <= count + 4'h1;
      end
    end
  end

endmodule

// File: logic/cpi_pkg.sv
// Types shared by the CAN power and interrupt block
package cpi_pkg;

  // Operating modes of the controller
  typedef enum logic [1:0] {
    CPI_NORMAL    = 2'b00,
    CPI_SLEEP     = 2'b01,
    CPI_SOFTRESET = 2'b10,
    CPI_POWERDOWN = 2'b11
  } cpi_mode_t;

endpackage
